// >>> shared/pfsp_pkg.sv
// Package of shared constants and types for the prefetch fill and stride prefetcher
package pfsp_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 48;              // Physical address width
    localparam int LINE_BYTES = 64;          // Cache line size in bytes
    localparam int LINE_OFS_W = $clog2(LINE_BYTES);
    localparam int LINE_W = ADDR_W - LINE_OFS_W; // Line number width
    localparam int MAX_OUTSTANDING = 8;      // Outstanding prefetch limit
    localparam int CNT_W = $clog2(MAX_OUTSTANDING + 1);
    localparam int TAG_W = $clog2(MAX_OUTSTANDING);
    localparam int WAY_W = 2;                // Way index width
    localparam logic [WAY_W-1:0] NT_WAY = 2'h0;       // Way for non-temporal fills
    localparam int STRIDE_NEXT = 1;          // Training step, lines
    localparam int STRIDE_AHEAD = 3;         // Target distance, lines

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PFSP_OP_PLAIN,                       // Plain load prefetch
        PFSP_OP_LEVEL_ZERO,                  // level_zero_hint_prefetch_op
        PFSP_OP_LEVEL_ONE,                   // level_one_hint_prefetch_op
        PFSP_OP_LEVEL_TWO,                   // level_two_hint_prefetch_op
        PFSP_OP_STORE,                       // Store-intent prefetch
        PFSP_OP_NONTEMPORAL                  // nontemporal_prefetch_op
    } pfsp_op_type;

    typedef enum logic [1:0] {
        PFSP_FILL_LOAD,                      // Normal fill, evict to L2
        PFSP_FILL_MODIFIED,                  // Fill already modified
        PFSP_FILL_NT_KEEP,                   // Non-temporal, L2 hit, evict to L2
        PFSP_FILL_NT_DROP                    // Non-temporal from memory, discard
    } pfsp_fill_type;

    typedef enum logic [1:0] {
        PFSP_CLASS_LOAD,
        PFSP_CLASS_STORE,
        PFSP_CLASS_NT
    } pfsp_class_type;
endpackage

// >>> design/pfsp_stride_det.sv
// Ascending next-line stride detector feeding second-level cache prefetches
`timescale 1ns/10ps
module pfsp_stride_det #(
    parameter int LW = pfsp_pkg::LINE_W
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic acc_valid_in,
    input wire logic [LW-1:0] acc_line_in,
    input wire logic hw_ready_in,
    output logic hw_valid_out,
    output logic [LW-1:0] hw_line_out
);
    import pfsp_pkg::*;

    logic last_valid_q, last_valid_d;        // A previous access is remembered
    logic [LW-1:0] last_line_q, last_line_d; // Line of previous access
    logic pend_q, pend_d;                    // Prefetch waiting for L2
    logic [LW-1:0] pend_line_q, pend_line_d; // Target line of pending prefetch
    logic hit_next;                          // Access is exactly one line up

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        last_valid_d = last_valid_q;
        last_line_d = last_line_q;
        pend_d = pend_q;
        pend_line_d = pend_line_q;
        // Only +1 trains: descending or skipping strides never match
        hit_next = acc_valid_in && last_valid_q &&
                   (acc_line_in == last_line_q + LW'(STRIDE_NEXT));
        if (pend_q && hw_ready_in) begin
            pend_d = 1'b0;
        end
        if (acc_valid_in) begin
            last_valid_d = 1'b1;
            last_line_d = acc_line_in;
        end
        // A new trigger replaces an unsent one; newest stream matters most
        if (hit_next) begin
            pend_d = 1'b1;
            pend_line_d = last_line_q + LW'(STRIDE_AHEAD);
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last_valid_q <= 1'b0;
            last_line_q <= '0;
            pend_q <= 1'b0;
            pend_line_q <= '0;
        end else begin
            last_valid_q <= last_valid_d;
            last_line_q <= last_line_d;
            pend_q <= pend_d;
            pend_line_q <= pend_line_d;
        end
    end

    assign hw_valid_out = pend_q;            // Fills go to L2 only
    assign hw_line_out = pend_line_q;
endmodule

// >>> design/pfsp_top.sv
// Software prefetch fill engine with hardware stride prefetcher
`timescale 1ns/10ps
// Summary of operation
// - Every prefetch that misses L1 reads the whole containing line; an L1 hit reads nothing
// - Load prefetches fill L1, evict to L2
// - Store-intent fills L1 in modified state
// - Non-temporal fills always use way zero
// - Non-temporal from memory discarded on eviction
// - Non-temporal L2 hit returns to L2
// - Control bits never alter or fault prefetches
// - Prefetch writes no architectural register
// - Hardware prefetcher fills L2 only
// - Lines l then l+1 prefetch l+3
// - Descending accesses never train the prefetcher
// - Line-skipping strides do not train
// - Line size is a 64-byte parameter
// - Hint levels behave as plain load
// - At most eight outstanding, held in order
module pfsp_top #(
    parameter int AW = pfsp_pkg::ADDR_W,
    parameter int LINE_BYTES_P = pfsp_pkg::LINE_BYTES,
    parameter int MAX_OUT_P = pfsp_pkg::MAX_OUTSTANDING
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Software prefetch request from the load-store pipeline
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire logic [AW-1:0] req_addr_in,
    input wire pfsp_pkg::pfsp_op_type req_op_in,
    input wire logic emulation_control_bit_in,
    input wire logic task_switched_control_bit_in,
    // L1 tag lookup result for the request line, same cycle
    input wire logic l1_hit_in,
    input wire logic [pfsp_pkg::WAY_W-1:0] l1_repl_way_in,
    // Demand access stream for the stride detector
    input wire logic acc_valid_in,
    input wire logic [AW-1:0] acc_addr_in,
    // Memory read request, whole line
    output logic mem_req_valid_out,
    input wire logic mem_req_ready_in,
    output logic [AW-1:0] mem_req_addr_out,
    output logic [pfsp_pkg::TAG_W-1:0] mem_req_tag_out,
    // Memory reply: fill arrived, and whether it came from L2
    input wire logic mem_rsp_valid_in,
    input wire logic [pfsp_pkg::TAG_W-1:0] mem_rsp_tag_in,
    input wire logic mem_rsp_l2_hit_in,
    // L1 fill command
    output logic l1_fill_valid_out,
    output logic [AW-1:0] l1_fill_addr_out,
    output logic [pfsp_pkg::WAY_W-1:0] l1_fill_way_out,
    output pfsp_pkg::pfsp_fill_type l1_fill_kind_out,
    // Hardware prefetch to L2
    output logic l2_pf_valid_out,
    input wire logic l2_pf_ready_in,
    output logic [AW-1:0] l2_pf_addr_out,
    // Completion and occupancy
    output logic req_done_out,
    output logic [pfsp_pkg::CNT_W-1:0] outstanding_out
);
    import pfsp_pkg::*;

    localparam int OFS_W = $clog2(LINE_BYTES_P);
    localparam int LW = AW - OFS_W;
    localparam int TW = $clog2(MAX_OUT_P);

    // Classify an opcode; hint levels fold into plain load
    function automatic pfsp_class_type op_class(input pfsp_op_type op);
        case (op)
            PFSP_OP_STORE: op_class = PFSP_CLASS_STORE;
            PFSP_OP_NONTEMPORAL: op_class = PFSP_CLASS_NT;
            default: op_class = PFSP_CLASS_LOAD;
        endcase
    endfunction

    // Align an address down to its line
    function automatic logic [AW-1:0] line_base(input logic [AW-1:0] a);
        line_base = {a[AW-1:OFS_W], {OFS_W{1'b0}}};
    endfunction

    // ------------------------------------------------------------
    // Miss tracking table
    // ------------------------------------------------------------
    logic [MAX_OUT_P-1:0] busy_q, busy_d;         // Entry in flight
    logic [MAX_OUT_P-1:0] sent_q, sent_d;         // Memory read already issued
    logic [AW-1:0] addr_q [MAX_OUT_P];            // Line address per entry
    logic [AW-1:0] addr_d [MAX_OUT_P];
    pfsp_class_type cls_q [MAX_OUT_P];            // Prefetch class per entry
    pfsp_class_type cls_d [MAX_OUT_P];
    logic [WAY_W-1:0] way_q [MAX_OUT_P];          // Target way per entry
    logic [WAY_W-1:0] way_d [MAX_OUT_P];
    logic [TW-1:0] alloc_q, alloc_d;              // Next entry to allocate
    logic [TW-1:0] issue_q, issue_d;              // Next entry to send, in order
    logic [CNT_W-1:0] cnt_q, cnt_d;               // Live entries
    logic fill_v_q, fill_v_d;                     // L1 fill strobe
    logic [AW-1:0] fill_a_q, fill_a_d;
    logic [WAY_W-1:0] fill_w_q, fill_w_d;
    pfsp_fill_type fill_k_q, fill_k_d;
    logic done_q, done_d;                         // Completion strobe
    logic take;                                   // Request accepted this cycle
    logic send;                                   // Memory read handed off
    logic retire;                                 // Fill returned this cycle

    // Control bits are deliberately unused: no gating, no faults
    // No architectural register write port exists at all

    // Next slot still busy holds the pipeline; an L1 hit needs no entry
    // Testing the slot, not the count, keeps out-of-order fills from overwriting
    assign req_ready_out = l1_hit_in || !busy_q[alloc_q];
    assign take = req_valid_in && req_ready_out;
    assign send = busy_q[issue_q] && !sent_q[issue_q] && mem_req_ready_in;
    assign retire = mem_rsp_valid_in && busy_q[mem_rsp_tag_in];

    // ------------------------------------------------------------
    // Table next state
    // ------------------------------------------------------------
    always_comb begin
        busy_d = busy_q;
        sent_d = sent_q;
        addr_d = addr_q;
        cls_d = cls_q;
        way_d = way_q;
        alloc_d = alloc_q;
        issue_d = issue_q;
        fill_v_d = 1'b0;
        fill_a_d = fill_a_q;
        fill_w_d = fill_w_q;
        fill_k_d = fill_k_q;
        done_d = 1'b0;
        // Present line: finish at once with no memory read
        if (take && l1_hit_in) begin
            done_d = 1'b1;
        end else if (take) begin
            busy_d[alloc_q] = 1'b1;
            sent_d[alloc_q] = 1'b0;
            addr_d[alloc_q] = line_base(req_addr_in);
            cls_d[alloc_q] = op_class(req_op_in);
            // Non-temporal ignores the replacement choice
            way_d[alloc_q] = (op_class(req_op_in) == PFSP_CLASS_NT) ?
                             NT_WAY : l1_repl_way_in;
            alloc_d = TW'(alloc_q + 1'b1);
        end
        // Reads leave strictly in allocation order
        if (send) begin
            sent_d[issue_q] = 1'b1;
            issue_d = TW'(issue_q + 1'b1);
        end
        // Fill returns: pick state and eviction policy
        if (retire) begin
            busy_d[mem_rsp_tag_in] = 1'b0;
            fill_v_d = 1'b1;
            done_d = 1'b1;
            fill_a_d = addr_q[mem_rsp_tag_in];
            fill_w_d = way_q[mem_rsp_tag_in];
            case (cls_q[mem_rsp_tag_in])
                PFSP_CLASS_STORE: fill_k_d = PFSP_FILL_MODIFIED;
                PFSP_CLASS_NT: begin
                    if (mem_rsp_l2_hit_in) begin
                        fill_k_d = PFSP_FILL_NT_KEEP;
                    end else begin
                        fill_k_d = PFSP_FILL_NT_DROP;
                    end
                end
                default: fill_k_d = PFSP_FILL_LOAD;
            endcase
        end
    end

    // Occupancy counter
    always_comb begin
        cnt_d = cnt_q;
        if (take && !l1_hit_in && !retire) begin
            cnt_d = CNT_W'(cnt_q + 1'b1);
        end else if (retire && !(take && !l1_hit_in)) begin
            cnt_d = CNT_W'(cnt_q - 1'b1);
        end
    end

    // ------------------------------------------------------------
    // Table registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_q <= '0;
            sent_q <= '0;
            alloc_q <= '0;
            issue_q <= '0;
            cnt_q <= '0;
            fill_v_q <= 1'b0;
            fill_a_q <= '0;
            fill_w_q <= '0;
            fill_k_q <= PFSP_FILL_LOAD;
            done_q <= 1'b0;
            for (int i = 0; i < MAX_OUT_P; i++) begin
                addr_q[i] <= '0;
                cls_q[i] <= PFSP_CLASS_LOAD;
                way_q[i] <= '0;
            end
        end else begin
            busy_q <= busy_d;
            sent_q <= sent_d;
            alloc_q <= alloc_d;
            issue_q <= issue_d;
            cnt_q <= cnt_d;
            fill_v_q <= fill_v_d;
            fill_a_q <= fill_a_d;
            fill_w_q <= fill_w_d;
            fill_k_q <= fill_k_d;
            done_q <= done_d;
            addr_q <= addr_d;
            cls_q <= cls_d;
            way_q <= way_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign mem_req_valid_out = busy_q[issue_q] && !sent_q[issue_q];
    assign mem_req_addr_out = addr_q[issue_q];
    assign mem_req_tag_out = issue_q;
    assign l1_fill_valid_out = fill_v_q;
    assign l1_fill_addr_out = fill_a_q;
    assign l1_fill_way_out = fill_w_q;
    assign l1_fill_kind_out = fill_k_q;
    assign req_done_out = done_q;
    assign outstanding_out = cnt_q;

    // ------------------------------------------------------------
    // Hardware stride prefetcher
    // ------------------------------------------------------------
    logic [LW-1:0] hw_line;                       // Target line from detector

    pfsp_stride_det #(
        .LW(LW)
    ) u_stride (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .acc_valid_in(acc_valid_in),
        .acc_line_in(acc_addr_in[AW-1:OFS_W]),
        .hw_ready_in(l2_pf_ready_in),
        .hw_valid_out(l2_pf_valid_out),
        .hw_line_out(hw_line)
    );

    assign l2_pf_addr_out = {hw_line, {OFS_W{1'b0}}};
endmodule

// >>> tb/pfsp_mem_model.sv
// Behavioural memory side: accepts line reads and answers them in order
`timescale 1ns/10ps
module pfsp_mem_model (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire logic [pfsp_pkg::TAG_W-1:0] req_tag_in,
    input wire logic hold_in,
    input wire logic l2_hit_in,
    output logic rsp_valid_out,
    output logic [pfsp_pkg::TAG_W-1:0] rsp_tag_out,
    output logic rsp_l2_hit_out
);
    import pfsp_pkg::*;
    logic [TAG_W-1:0] pend_q[$]; // Accepted tags awaiting a reply
    logic [1:0] lat_q; // Reply latency counter
    // ------------------------------------------------------------
    // Accept and reply
    // ------------------------------------------------------------
    // Ready toggles so a request raised while it is low meets a slow accept
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            req_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_tag_out <= '0;
            rsp_l2_hit_out <= 1'b0;
            lat_q <= 2'h0;
            pend_q.delete();
        end else begin
            req_ready_out <= ~req_ready_out;
            rsp_valid_out <= 1'b0;
            // Idle reply lines never repeat the last value
            rsp_tag_out <= ~rsp_tag_out;
            rsp_l2_hit_out <= ~rsp_l2_hit_out;
            if (req_valid_in && req_ready_out) begin
                pend_q.push_back(req_tag_in);
            end
            // Hold keeps fills back so the outstanding limit can be reached
            if (pend_q.size() > 0 && !hold_in) begin
                lat_q <= lat_q + 2'h1;
                if (lat_q == 2'h3) begin
                    rsp_valid_out <= 1'b1;
                    rsp_tag_out <= pend_q.pop_front();
                    rsp_l2_hit_out <= l2_hit_in;
                end
            end
        end
    end
endmodule

// >>> tb/pfsp_top_monitor.sv
// Port-level assertions for the prefetch fill and stride prefetcher
`timescale 1ns/10ps
module pfsp_top_monitor #(
    parameter int AW = 48,
    parameter int LINE_BYTES_P = 64,
    parameter int MAX_OUT_P = 8
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input wire logic req_ready_out,
    input wire logic l1_hit_in,
    input wire logic acc_valid_in,
    input wire logic [AW-1:0] acc_addr_in,
    input wire logic mem_req_valid_out,
    input wire logic mem_req_ready_in,
    input wire logic [AW-1:0] mem_req_addr_out,
    input wire logic [pfsp_pkg::TAG_W-1:0] mem_req_tag_out,
    input wire logic mem_rsp_valid_in,
    input wire logic l1_fill_valid_out,
    input wire logic [pfsp_pkg::WAY_W-1:0] l1_fill_way_out,
    input wire pfsp_pkg::pfsp_fill_type l1_fill_kind_out,
    input wire logic l2_pf_valid_out,
    input wire logic l2_pf_ready_in,
    input wire logic [AW-1:0] l2_pf_addr_out,
    input wire logic req_done_out,
    input wire logic [pfsp_pkg::CNT_W-1:0] outstanding_out
);
    import pfsp_pkg::*;
    localparam int LOFS = $clog2(LINE_BYTES_P); // Offset bits inside a line
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Two accesses on consecutive edges, the second one line higher
    sequence s_rise_pair;
        acc_valid_in ##1
        (acc_valid_in && acc_addr_in[AW-1:LOFS] == $past(acc_addr_in[AW-1:LOFS]) + 1);
    endsequence
    // Two accesses, the second one line lower, no prefetch pending
    sequence s_fall_pair;
        (acc_valid_in && !l2_pf_valid_out) ##1 (acc_valid_in && !l2_pf_valid_out
        && acc_addr_in[AW-1:LOFS] == $past(acc_addr_in[AW-1:LOFS]) - 1);
    endsequence
    a_hit_done: assert property (
        req_valid_in && req_ready_out && l1_hit_in |=> req_done_out)
        else $error("L1 hit did not complete next cycle");
    a_full_refuse: assert property (
        outstanding_out == MAX_OUT_P && !l1_hit_in |-> !req_ready_out)
        else $error("request accepted while full");
    a_count_max: assert property (outstanding_out <= MAX_OUT_P)
        else $error("outstanding count above limit");
    a_line_align: assert property (
        mem_req_valid_out |-> mem_req_addr_out[LOFS-1:0] == 0)
        else $error("memory read not line aligned");
    a_req_stands: assert property (
        mem_req_valid_out && !mem_req_ready_in |=> mem_req_valid_out
        && $stable(mem_req_addr_out) && $stable(mem_req_tag_out))
        else $error("memory read dropped before accept");
    a_rsp_fill: assert property (
        mem_rsp_valid_in |=> l1_fill_valid_out && req_done_out)
        else $error("reply not followed by fill and done");
    a_nt_way: assert property (
        l1_fill_valid_out && (l1_fill_kind_out == PFSP_FILL_NT_KEEP
        || l1_fill_kind_out == PFSP_FILL_NT_DROP) |-> l1_fill_way_out == NT_WAY)
        else $error("non-temporal fill outside way zero");
    a_stride_ahead: assert property (s_rise_pair |=> l2_pf_valid_out
        && l2_pf_addr_out[AW-1:LOFS] == $past(acc_addr_in[AW-1:LOFS]) + 2
        && l2_pf_addr_out[LOFS-1:0] == 0)
        else $error("stride prefetch missing or wrong line");
    a_pf_stands: assert property (
        l2_pf_valid_out && !l2_pf_ready_in |=> l2_pf_valid_out)
        else $error("hardware prefetch dropped before accept");
    a_no_desc: assert property (s_fall_pair |=> !l2_pf_valid_out)
        else $error("descending access trained prefetcher");
endmodule
bind pfsp_top pfsp_top_monitor #(.AW(AW), .LINE_BYTES_P(LINE_BYTES_P), .MAX_OUT_P(MAX_OUT_P))
    u_mon (.*);

// >>> tb/tb.sv
// Self-checking bench for the prefetch fill and stride prefetcher
`timescale 1ns/10ps
module tb;
    import pfsp_pkg::*;
    logic core_clk_in, rst_n_in, req_valid_in, req_ready_out, l1_hit_in, acc_valid_in;
    logic emulation_control_bit_in, task_switched_control_bit_in, hold, l2_hit;
    logic mem_req_valid_out, mem_req_ready_in, mem_rsp_valid_in, mem_rsp_l2_hit_in;
    logic l1_fill_valid_out, l2_pf_valid_out, l2_pf_ready_in, req_done_out;
    logic [ADDR_W-1:0] req_addr_in, acc_addr_in, mem_req_addr_out, l1_fill_addr_out;
    logic [ADDR_W-1:0] l2_pf_addr_out, f_addr;
    logic [TAG_W-1:0] mem_req_tag_out, mem_rsp_tag_in;
    logic [WAY_W-1:0] l1_repl_way_in, l1_fill_way_out, f_way;
    logic [CNT_W-1:0] outstanding_out;
    pfsp_op_type req_op_in;
    pfsp_fill_type l1_fill_kind_out, f_kind;
    logic [ADDR_W-1:0] mq[$]; // Accepted memory read addresses
    logic [TAG_W-1:0] tq[$]; // Their tags
    int err_total = 0, n_checks = 0, fills = 0, dones = 0, pfs = 0, cyc = 0;
    pfsp_top DUT (.*);
    pfsp_mem_model MEM (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .req_valid_in(mem_req_valid_out), .req_ready_out(mem_req_ready_in),
        .req_tag_in(mem_req_tag_out), .hold_in(hold), .l2_hit_in(l2_hit),
        .rsp_valid_out(mem_rsp_valid_in), .rsp_tag_out(mem_rsp_tag_in),
        .rsp_l2_hit_out(mem_rsp_l2_hit_in));
    // ------------------------------------------------------------
    // Observers and timeout
    // ------------------------------------------------------------
    // Registered outputs read at the edge give last cycle's settled value
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (mem_req_valid_out === 1'b1 && mem_req_ready_in === 1'b1) begin
            mq.push_back(mem_req_addr_out);
            tq.push_back(mem_req_tag_out);
        end
        if (l1_fill_valid_out === 1'b1) begin
            fills <= fills + 1;
            f_addr <= l1_fill_addr_out;
            f_way <= l1_fill_way_out;
            f_kind <= l1_fill_kind_out;
        end
        if (req_done_out === 1'b1) dones <= dones + 1;
        if (l2_pf_valid_out === 1'b1) pfs <= pfs + 1;
        if (cyc == 5000) begin
            err_total++;
            results();
        end
    end
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Holds the request until an edge sees ready, then leaves it up
    task automatic send(input logic [ADDR_W-1:0] a, input pfsp_op_type op, input logic hit);
        req_valid_in = 1'b1;
        req_addr_in = a;
        req_op_in = op;
        l1_hit_in = hit;
        while (req_ready_out !== 1'b1) begin
            @(posedge core_clk_in);
            #1;
        end
        @(posedge core_clk_in);
        #1;
    endtask
    task automatic idle(input int n);
        req_valid_in = 1'b0;
        l1_hit_in = 1'b0;
        acc_valid_in = 1'b0;
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    task automatic acc(input int line);
        acc_valid_in = 1'b1;
        acc_addr_in = ADDR_W'(line) * LINE_BYTES + 48'h21;
        @(posedge core_clk_in);
        #1;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_hit();
        int d0 = dones;
        int m0 = mq.size();
        send(48'h1234, PFSP_OP_PLAIN, 1'b1);
        idle(4);
        chk("hit done", dones - d0, 1);
        chk("hit reads", mq.size() - m0, 0);
        $display("test hit done");
    endtask
    // Every opcode, with the control bits in all combinations
    task automatic t_ops();
        pfsp_op_type ops[7] = '{PFSP_OP_PLAIN, PFSP_OP_LEVEL_ZERO, PFSP_OP_LEVEL_ONE,
            PFSP_OP_LEVEL_TWO, PFSP_OP_STORE, PFSP_OP_NONTEMPORAL, PFSP_OP_NONTEMPORAL};
        pfsp_fill_type ek[7] = '{PFSP_FILL_LOAD, PFSP_FILL_LOAD, PFSP_FILL_LOAD,
            PFSP_FILL_LOAD, PFSP_FILL_MODIFIED, PFSP_FILL_NT_DROP, PFSP_FILL_NT_KEEP};
        logic [ADDR_W-1:0] a;
        int f0;
        for (int i = 0; i < 7; i++) begin
            a = 48'h10000 + ADDR_W'(i) * 48'h140 + 48'hD;
            l2_hit = (i == 6);
            emulation_control_bit_in = i[0];
            task_switched_control_bit_in = i[1];
            l1_repl_way_in = i[0] ? 2'h1 : 2'h3;
            f0 = fills;
            send(a, ops[i], 1'b0);
            idle(0);
            for (int k = 0; k < 60 && fills == f0; k++) @(posedge core_clk_in);
            #1;
            chk("read addr", mq[$], {a[ADDR_W-1:6], 6'h0});
            chk("fill line", f_addr[ADDR_W-1:6], a[ADDR_W-1:6]);
            chk("fill kind", f_kind, ek[i]);
            chk("fill way", f_way, i > 4 ? NT_WAY : (i[0] ? 2'h1 : 2'h3));
        end
        $display("test ops done");
    endtask
    task automatic t_full();
        int d0 = dones;
        int m0 = mq.size();
        hold = 1'b1;
        for (int i = 0; i < 8; i++) send(48'h80000 + ADDR_W'(i) * 64, PFSP_OP_PLAIN, 1'b0);
        req_addr_in = 48'h80000 + 48'h200;
        repeat (6) @(posedge core_clk_in);
        #1;
        chk("full ready", req_ready_out, 1'b0);
        chk("full count", outstanding_out, 8);
        hold = 1'b0;
        send(48'h80200, PFSP_OP_PLAIN, 1'b0);
        idle(0);
        for (int k = 0; k < 200 && dones < d0 + 9; k++) @(posedge core_clk_in);
        #1;
        chk("full done", dones - d0, 9);
        for (int i = 0; i < 9; i++) begin
            chk("read order", mq[m0 + i], 48'h80000 + ADDR_W'(i) * 64);
            chk("tag order", tq[m0 + i], TAG_W'(tq[m0] + TAG_W'(i)));
        end
        $display("test full done");
    endtask
    task automatic t_stride();
        int f0 = fills;
        int p0;
        l2_pf_ready_in = 1'b0;
        acc(10);
        acc(11);
        idle(0);
        for (int k = 0; k < 4 && l2_pf_valid_out !== 1'b1; k++) @(posedge core_clk_in);
        #1;
        chk("pf addr", l2_pf_addr_out, 13 * LINE_BYTES);
        idle(2);
        chk("pf stands", l2_pf_valid_out, 1'b1);
        l2_pf_ready_in = 1'b1;
        idle(1);
        chk("pf taken", l2_pf_valid_out, 1'b0);
        p0 = pfs;
        acc(20);
        acc(19);
        idle(4);
        chk("desc pf", pfs - p0, 0);
        acc(30);
        acc(32);
        idle(4);
        chk("skip pf", pfs - p0, 0);
        chk("pf no fill", fills - f0, 0);
        $display("test stride done");
    endtask
    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end
    initial begin
        rst_n_in = 1'b0;
        {req_valid_in, l1_hit_in, acc_valid_in, hold, l2_hit, l2_pf_ready_in} = '0;
        {emulation_control_bit_in, task_switched_control_bit_in} = '0;
        req_addr_in = '0;
        acc_addr_in = '0;
        req_op_in = PFSP_OP_PLAIN;
        l1_repl_way_in = 2'h0;
        repeat (2) @(posedge core_clk_in);
        #1;
        rst_n_in = 1'b1;
        t_hit();
        t_ops();
        t_full();
        t_stride();
        results();
    end
endmodule
